// file: fr_i2c_slave.sv
// two-wire slave front end with its 8k-byte array
`timescale 1ns/1ns
`include "fr_i2c_consts.svh"

module fr_i2c_slave import fr_i2c_pkg::*; #(
    parameter int ADDR_W = `FR_ADDR_W,
    parameter int DEPTH = `FR_DEPTH
) (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial bus, open drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // straps and protect
    input wire logic [2:0] select_pins,
    input wire logic wp_i,
    // status toward the core
    output logic high_speed_mode
);

    // ****************************************
    // bus condition detectors
    // ****************************************

    // start and stop are SDA edges with SCL high, so only SDA
    // can see them; each flips a toggle read on SCL edges
    logic start_tgl_ff, stop_tgl_ff;

    // falling data with clock high opens a command
    always_ff @(negedge sda_i or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl_ff <= 1'b0;
        end else if (scl_i) begin
            start_tgl_ff <= ~start_tgl_ff;
        end
    end

    // rising data with clock high closes a command
    always_ff @(posedge sda_i or negedge rst_n) begin
        if (!rst_n) begin
            stop_tgl_ff <= 1'b0;
        end else if (scl_i) begin
            stop_tgl_ff <= ~stop_tgl_ff;
        end
    end

    // ****************************************
    // link reset
    // ****************************************

    // asserts at once, releases on SCL: the link clock may be
    // parked while the core is in reset
    logic [1:0] link_rst_ff;
    logic link_rst_n;

    always_ff @(posedge scl_i or negedge rst_n) begin
        if (!rst_n) begin
            link_rst_ff <= 2'b00;
        end else begin
            link_rst_ff <= {link_rst_ff[0], 1'b1};
        end
    end

    assign link_rst_n = link_rst_ff[1];

    // ****************************************
    // pin qualification on the link clock
    // ****************************************

    // bit 3 is write protect, bits 2..0 the select straps
    logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_held_ff, nxt_pin_held;
    logic wp_held;

    // a bit moves only once the second and third stage agree
    assign nxt_pin_held = (pin_s2_ff & pin_s3_ff)
        | (pin_held_ff & (pin_s2_ff | pin_s3_ff));
    assign wp_held = pin_held_ff[3];

    always_ff @(posedge scl_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pin_s1_ff <= `FR_PIN_RST;
            pin_s2_ff <= `FR_PIN_RST;
            pin_s3_ff <= `FR_PIN_RST;
            pin_held_ff <= `FR_PIN_RST;
        end else begin
            pin_s1_ff <= {wp_i, select_pins};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            pin_held_ff <= nxt_pin_held;
        end
    end

    // ****************************************
    // link sequencer state and decode on the rising SCL edge
    // ****************************************

    fr_state_t state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, tx_ff, nxt_tx, byte_in;
    logic ack_ff, nxt_ack, start_seen_ff, stop_seen_ff, hs_tgl_ff;
    logic [ADDR_W-1:0] ptr_ff, nxt_ptr;
    logic [7:0] mem_ff [0:DEPTH-1];
    logic start_pend, stop_pend, live, byte_done, ack_slot, in_dev, dev_hit, hs_hit;
    logic rd_cmd, set_hi, set_lo, wr_hit, mem_we, rd_more, rd_nack, load_rd;

    // the protocol keeps SDA still across SCL rise, so the
    // toggles and SDA are stable when sampled here
    assign start_pend = start_tgl_ff ^ start_seen_ff;
    assign stop_pend = stop_tgl_ff ^ stop_seen_ff;
    assign live = !start_pend && !stop_pend;
    assign byte_in = {shift_ff[6:0], sda_i};
    assign byte_done = (cnt_ff == `FR_BIT_LAST);
    assign ack_slot = (cnt_ff == `FR_ACK_SLOT);
    assign in_dev = live && (state_ff == st_dev) && byte_done;

    // slave address: type, straps, then direction
    assign dev_hit = in_dev
        && (byte_in[`FR_TYPE_MSB:`FR_TYPE_LSB] == `FR_DEV_TYPE)
        && (byte_in[`FR_SEL_MSB:`FR_SEL_LSB] == pin_held_ff[2:0]);
    assign rd_cmd = byte_in[`FR_RW_BIT];
    assign hs_hit = in_dev
        && (byte_in[7:`FR_HS_LSB] == `FR_HS_CODE);

    // word address and data bytes
    assign set_hi = live && (state_ff == st_ahi) && byte_done;
    assign set_lo = live && (state_ff == st_alo) && byte_done;
    assign wr_hit = live && (state_ff == st_wdat) && byte_done;
    assign mem_we = wr_hit && !wp_held;

    // master acknowledge slot of a read, skipping our own ack
    assign rd_more = live && (state_ff == st_rdat) && ack_slot
        && !ack_ff && !sda_i;
    assign rd_nack = live && (state_ff == st_rdat) && ack_slot
        && !ack_ff && sda_i;
    assign load_rd = (dev_hit && rd_cmd) || rd_more;

    // ****************************************
    // sequencer next state
    // ****************************************

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_ack = 1'b0;
        if (start_pend) begin
            nxt_state = st_dev;
            nxt_cnt = `FR_CNT_START;
        end else if (stop_pend) begin
            nxt_state = st_idle;
            nxt_cnt = `FR_CNT_RST;
        end else begin
            unique case (state_ff)
                st_idle: begin
                    nxt_cnt = `FR_CNT_RST;
                end
                st_dev: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (byte_done) begin
                        // unmatched or high-speed code: silent until restart
                        nxt_state = st_idle;
                        if (dev_hit) begin
                            nxt_ack = 1'b1;
                            nxt_state = rd_cmd ? st_rdat : st_ahi;
                        end
                    end
                end
                st_ahi, st_alo, st_wdat: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (ack_slot) begin
                        nxt_cnt = `FR_CNT_RST;
                    end
                    if (byte_done) begin
                        nxt_ack = 1'b1;
                        if (state_ff == st_ahi) begin
                            nxt_state = st_alo;
                        end else begin
                            nxt_state = st_wdat;
                        end
                    end
                end
                st_rdat: begin
                    nxt_cnt = cnt_ff + 4'h1;
                    if (ack_slot) begin
                        nxt_cnt = `FR_CNT_RST;
                    end
                    if (rd_nack) begin
                        nxt_state = st_idle;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // address pointer and read data
    // ****************************************

    // upper byte keeps only the bits the array needs
    assign nxt_ptr = set_hi ? {byte_in[ADDR_W-9:0], ptr_ff[7:0]}
        : set_lo ? {ptr_ff[ADDR_W-1:8], byte_in}
        : (wr_hit || load_rd) ? ptr_ff + 1'b1
        : ptr_ff;
    assign nxt_tx = load_rd ? mem_ff[ptr_ff] : tx_ff;

    // ****************************************
    // link registers, rising SCL
    // ****************************************

    always_ff @(posedge scl_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_ff <= st_idle;
            cnt_ff <= `FR_CNT_RST;
            shift_ff <= `FR_BYTE_RST;
            tx_ff <= `FR_BYTE_RST;
            ack_ff <= 1'b0;
            ptr_ff <= `FR_PTR_RST;
            hs_tgl_ff <= 1'b0;
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            shift_ff <= byte_in;
            tx_ff <= nxt_tx;
            ack_ff <= nxt_ack;
            ptr_ff <= nxt_ptr;
            hs_tgl_ff <= hs_tgl_ff ^ hs_hit;
            start_seen_ff <= start_tgl_ff;
            stop_seen_ff <= stop_tgl_ff;
        end
    end

    // array store: flip-flops, no reset, written in the same
    // edge that takes the byte, so there is no busy period
    always_ff @(posedge scl_i) begin
        if (mem_we) begin
            mem_ff[ptr_ff] <= byte_in;
        end
    end

    // ****************************************
    // data driver, falling SCL
    // ****************************************

    logic nxt_oe, drive_bit, sda_oe_ff, sda_o_ff;

    // low for an ack or a zero data bit, released otherwise
    assign drive_bit = !tx_ff[3'h7 - cnt_ff[2:0]];
    assign nxt_oe = (ack_ff && ack_slot)
        || ((state_ff == st_rdat) && !cnt_ff[3] && drive_bit);

    always_ff @(negedge scl_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe_ff <= 1'b0;
            sda_o_ff <= 1'b0;
        end else begin
            sda_oe_ff <= nxt_oe;
            sda_o_ff <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_ff;
    assign sda_o = sda_o_ff;

    // ****************************************
    // core side: stop and high-speed events
    // ****************************************

    // bit 1 is the high-speed toggle, bit 0 the stop toggle
    logic [1:0] ev_s1_ff, ev_s2_ff, ev_s3_ff, ev_lvl_ff, nxt_ev_lvl, ev_hit;
    logic hs_ff, nxt_hs;

    assign nxt_ev_lvl = (ev_s2_ff & ev_s3_ff)
        | (ev_lvl_ff & (ev_s2_ff | ev_s3_ff));
    assign ev_hit = nxt_ev_lvl ^ ev_lvl_ff;
    // a code that lands with a stop still wins
    assign nxt_hs = ev_hit[1] || (hs_ff && !ev_hit[0]);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ev_s1_ff <= 2'b00;
            ev_s2_ff <= 2'b00;
            ev_s3_ff <= 2'b00;
            ev_lvl_ff <= 2'b00;
            hs_ff <= 1'b0;
        end else begin
            ev_s1_ff <= {hs_tgl_ff, stop_tgl_ff};
            ev_s2_ff <= ev_s1_ff;
            ev_s3_ff <= ev_s2_ff;
            ev_lvl_ff <= nxt_ev_lvl;
            hs_ff <= nxt_hs;
        end
    end

    assign high_speed_mode = hs_ff;

    // ****************************************
    // checks
    // ****************************************

    sequence s_addr_ack;
        ack_ff && (cnt_ff == `FR_ACK_SLOT);
    endsequence

    sequence s_next_byte;
        (state_ff == st_rdat) && (cnt_ff == `FR_CNT_RST);
    endsequence

    a_start_opens: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        start_pend |=> (state_ff == st_dev) && (cnt_ff == `FR_CNT_START)
    ) else $error("start did not open address phase");
    a_stop_closes: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        (stop_pend && !start_pend) |=> (state_ff == st_idle)
    ) else $error("stop did not end operation");
    a_match_ack: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        dev_hit |=> s_addr_ack
    ) else $error("matching address not acknowledged");
    a_write_byte_ack: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        (set_hi || set_lo || wr_hit) |=> s_addr_ack
    ) else $error("write byte not acknowledged");
    a_read_next: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        rd_more |=> s_next_byte ##1 (cnt_ff == `FR_CNT_START)
    ) else $error("ack did not bring next read byte");
    a_nack_release: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        rd_nack |=> (state_ff == st_idle) ##0 !ack_ff
    ) else $error("read not ended after missing ack");
    // the location itself must keep its old contents
    a_wp_blocks: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        (wr_hit && wp_held) |=> (mem_ff[$past(ptr_ff)] == $past(mem_ff[ptr_ff]))
    ) else $error("write while protected");
    a_byte_stored: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        (wr_hit && !wp_held) |=> (mem_ff[$past(ptr_ff)] == $past(byte_in))
    ) else $error("data byte not stored at once");
    a_ptr_wrap: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        (wr_hit && (&ptr_ff)) |=> (ptr_ff == `FR_PTR_RST)
    ) else $error("pointer did not wrap to zero");
    a_hs_silent: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        hs_hit |=> !ack_ff && (state_ff == st_idle)
    ) else $error("high-speed code acknowledged");
    // the read bit must already stand when the master samples it
    a_bit_ready_rise: assert property (
        @(posedge scl_i) disable iff (!link_rst_n)
        ((state_ff == st_rdat) && !cnt_ff[3]) |-> (sda_oe_ff == !tx_ff[3'h7 - cnt_ff[2:0]])
    ) else $error("read bit not set up on falling clock");
    a_hs_until_stop: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ev_hit == 2'b01) |=> !high_speed_mode [*2]
    ) else $error("high-speed mode outlived stop");

endmodule // fr_i2c_slave

// file: fr_i2c_consts.svh
// constants of the two-wire ferroelectric memory slave
// What this block does
// - a start, SDA falling with SCL high, opens every command
// - a stop, SDA rising with SCL high, ends the current operation
// - traffic is 8-bit bytes, each followed by an acknowledge bit
// - bits are sampled on SCL rise and driven bits change on SCL fall
// - after eight bits the sender releases SDA; the receiver pulls low in slot nine
// - after start and a matching slave address the device acknowledges low
// - in a write every word-address and data byte is acknowledged low
// - in a read a low acknowledge without stop brings the next byte out
// - no low acknowledge in a read: stop driving, wait for stop, end read
// - only slave addresses whose top four bits are 1010 are answered
// - the next three address bits must match the select pins
// - address bit zero picks direction, 0 write and 1 read
// - write protect high blocks every write; low or open allows them
// - byte write is start, address, two word-address bytes, one data byte, stop
// - each further page byte goes to the next address, wrapping to zero
// - a page burst past 8,192 bytes overwrites its own first locations
// - the array is 8,192 bytes selected by the word address
// - writes need no busy time; the next command is taken at once
// - high-speed mode lasts from its code until the next stop
// - random read is address write, two address bytes, restart, read, nack, stop
// - a current-address read returns the byte after the last one touched
`ifndef FR_I2C_CONSTS_SVH
`define FR_I2C_CONSTS_SVH
`define FR_ADDR_W 13
`define FR_DEPTH 8192
`define FR_DEV_TYPE 4'ha
`define FR_HS_CODE 5'h01
`define FR_TYPE_MSB 7
`define FR_TYPE_LSB 4
`define FR_SEL_MSB 3
`define FR_SEL_LSB 1
`define FR_RW_BIT 0
`define FR_HS_LSB 3
`define FR_BIT_LAST 4'h7
`define FR_ACK_SLOT 4'h8
`define FR_CNT_RST 4'h0
`define FR_CNT_START 4'h1
`define FR_PTR_RST 13'h0000
`define FR_BYTE_RST 8'h00
`define FR_PIN_RST 4'h0
`endif

// file: fr_i2c_pkg.sv
// types shared by the two-wire memory slave
package fr_i2c_pkg;
    // one-hot link sequencer states
    typedef enum logic [5:0] {
        st_idle = 6'h01,
        st_dev = 6'h02,
        st_ahi = 6'h04,
        st_alo = 6'h08,
        st_wdat = 6'h10,
        st_rdat = 6'h20
    } fr_state_t;
endpackage

// file: fr_bus_master.sv
// bus master model that drives the two-wire memory slave
`timescale 1ns/1ns

module fr_bus_master (
    // bus lines, sda_m high means released
    output logic scl,
    output logic sda_m,
    input wire logic sda_line
);
    // quarter of the 48 ns link period
    localparam int QTR = 12;

    // bus idles with both lines high
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // ****************************************
    // frame conditions
    // ****************************************
    // start or repeated start; scl is parked high between frames
    task automatic start();
        if (scl == 1'b0) begin
            sda_m = 1'b1;
            #QTR scl = 1'b1;
            #QTR;
        end
        sda_m = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // stop leaves the bus parked high
    task automatic stop();
        sda_m = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_m = 1'b1;
        #QTR;
    endtask

    // ****************************************
    // bits and bytes
    // ****************************************
    // data moves only while scl is low, read back during the high phase
    task automatic bit_xfer(input logic b, output logic r);
        sda_m = b;
        #QTR scl = 1'b1;
        #QTR r = sda_line;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // msb first, then released for the acknowledge slot
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask

    // released while the slave sends, then our own acknowledge
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(~ack, r);
    endtask

    // clocks with sda high and no start, so the slave can qualify its straps
    task automatic idle(input int n);
        logic r;
        for (int i = 0; i < n; i++) begin
            bit_xfer(1'b1, r);
        end
        #QTR scl = 1'b1;
        #QTR;
    endtask
endmodule // fr_bus_master

// file: test_fr_i2c_slave.sv
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ns

module test_fr_i2c_slave;
    logic core_clk, rst_n, scl, sda_m, sda_o, sda_oe, wp_i, high_speed_mode, ack;
    logic [2:0] select_pins;
    logic [7:0] mem [0:8191];
    logic [12:0] ptr, a;
    int mismatches, cmp_count, cycles, seed, n;
    // open drain wire with pull-up
    wire sda_line = sda_m & ~(sda_oe & ~sda_o);

    fr_i2c_slave fr_i2c_slave_inst (
        .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .select_pins(select_pins), .wp_i(wp_i),
        .high_speed_mode(high_speed_mode)
    );
    fr_bus_master fr_bus_master_inst (.scl(scl), .sda_m(sda_m), .sda_line(sda_line));

    // 50 MHz core clock
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // a hang costs a mismatch and ends the run; the tests need a few thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] dev_byte(input logic [2:0] sel, input logic rd);
        return {4'ha, sel, rd};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write-addressed frame up to the word address; junk in the unused upper bits
    task automatic set_addr(input logic [12:0] wa);
        fr_bus_master_inst.start();
        fr_bus_master_inst.wr_byte(dev_byte(select_pins, 1'b0), ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        fr_bus_master_inst.wr_byte({3'($random(seed)), wa[12:8]}, ack);
        chk("hi ack", 8'h01, {7'h0, ack});
        fr_bus_master_inst.wr_byte(wa[7:0], ack);
        chk("lo ack", 8'h01, {7'h0, ack});
        ptr = wa;
    endtask

    // random data burst; a protected write leaves the array as it was
    task automatic wr_burst(input logic [12:0] wa, input int cnt);
        logic [7:0] v;
        set_addr(wa);
        for (int i = 0; i < cnt; i++) begin
            v = 8'($random(seed));
            fr_bus_master_inst.wr_byte(v, ack);
            chk("data ack", 8'h01, {7'h0, ack});
            if (wp_i === 1'b0) mem[ptr] = v;
            ptr = ptr + 13'h1;
        end
        fr_bus_master_inst.stop();
    endtask

    // read from the pointer, nack the last byte, then the slave must be off the wire
    task automatic rd_burst(input int cnt);
        logic [7:0] v;
        fr_bus_master_inst.start();
        fr_bus_master_inst.wr_byte(dev_byte(select_pins, 1'b1), ack);
        chk("read addr ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < cnt; i++) begin
            fr_bus_master_inst.rd_byte(i < cnt - 1, v);
            chk("read data", mem[ptr], v);
            ptr = ptr + 13'h1;
        end
        fr_bus_master_inst.bit_xfer(1'b1, ack);
        chk("released after nack", 8'h01, {7'h0, ack});
        fr_bus_master_inst.stop();
    endtask

    task automatic results();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 7599;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        rst_n = 1'b0;
        wp_i = 1'b0;
        select_pins = 3'($random(seed));
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        fr_bus_master_inst.idle(6);
        chk("hs after reset", 8'h00, {7'h0, high_speed_mode});
        // foreign type code and each wrong strap bit are ignored
        fr_bus_master_inst.start();
        fr_bus_master_inst.wr_byte({4'h5, select_pins, 1'b0}, ack);
        chk("foreign type", 8'h00, {7'h0, ack});
        for (int i = 0; i < 3; i++) begin
            fr_bus_master_inst.start();
            fr_bus_master_inst.wr_byte(dev_byte(select_pins ^ (3'h1 << i), 1'b0), ack);
            chk("foreign strap", 8'h00, {7'h0, ack});
        end
        fr_bus_master_inst.stop();
        // wrap past the last location, random read, then current read
        wr_burst(13'h0000, 8);
        wr_burst(13'h1ffe, 4);
        set_addr(13'h1ffe);
        rd_burst(4);
        rd_burst(2);
        // random bursts written and read straight back
        for (int k = 0; k < 4; k++) begin
            a = 13'($random(seed));
            n = 1 + ($random(seed) & 7);
            wr_burst(a, n);
            set_addr(a);
            rd_burst(n);
        end
        // protect raised only between frames, then the array must not change
        @(negedge core_clk);
        wp_i = 1'b1;
        fr_bus_master_inst.idle(4);
        wr_burst(a, n);
        set_addr(a);
        rd_burst(n);
        @(negedge core_clk);
        wp_i = 1'b0;
        fr_bus_master_inst.idle(4);
        // high-speed code first, a write under it, mode ends at the stop
        fr_bus_master_inst.start();
        fr_bus_master_inst.wr_byte(8'h08 | 8'($random(seed) & 7), ack);
        chk("hs code nack", 8'h00, {7'h0, ack});
        repeat (8) @(negedge core_clk);
        chk("high_speed_mode on", 8'h01, {7'h0, high_speed_mode});
        wr_burst(13'h0100, 3);
        repeat (8) @(negedge core_clk);
        chk("high_speed_mode off", 8'h00, {7'h0, high_speed_mode});
        set_addr(13'h0100);
        rd_burst(3);
        results();
    end
endmodule // test_fr_i2c_slave
